// ===== rtl/cpio_pkg.sv
// constants for the control and port input instruction slice
package cpio_pkg;
	localparam int OPCODE_W = 10;
	localparam int ACC_W = 4;
	localparam logic [9:0] OP_IRQ_MASK = 10'h004;
	localparam logic [9:0] OP_IRQ_UNMASK = 10'h005;
	localparam logic [9:0] OP_WDOG_HALT_ARM = 10'h29C;
	localparam logic [9:0] OP_SLEEP_ARM = 10'h05B;
	localparam logic [9:0] OP_SLEEP = 10'h008;
	localparam logic [9:0] OP_DEEP_SLEEP = 10'h00A;
	localparam logic [9:0] OP_READ_SINGLE_BIT_PORT = 10'h26F;
	localparam logic [9:0] OP_READ_PORT_ZERO = 10'h260;
	localparam logic IRQ_GATE_RESET = 1'h0;
	localparam logic [3:0] ACC_RESET = 4'h0;
	localparam logic WDOG_ARM_RESET = 1'h0;
	localparam logic SLEEP_ARM_RESET = 1'h0;
	localparam logic CARRY_RESET = 1'h0;
	localparam logic PULSE_RESET = 1'h0;
endpackage

// ===== rtl/cpio_decoder.sv
// decoder and executor for interrupt gate, arming and port read instructions
// Notes on behaviour
// - mask opcode clears the interrupt gate flag
// - unmask opcode sets the interrupt gate flag
// - watchdog halt arm opcode arms watchdog stop
// - sleep arm makes a sleep or deep sleep effective only as the very next instruction
// - single-bit port read copies pin to bit0
// - single-bit port read zeroes accumulator bits 3..1
// - port zero read loads all four levels
`timescale 1ns/10ps
module cpio_decoder
	import cpio_pkg::*;
#(
	parameter int ACC_WIDTH = ACC_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [OPCODE_W-1:0] instr_opcode,
	input wire logic [ACC_WIDTH-1:0] acc_in,
	input wire logic carry_in,
	input wire logic single_bit_port,
	input wire logic [ACC_WIDTH-1:0] quad_io_port_zero,
	output logic [ACC_WIDTH-1:0] acc_out,
	output logic acc_we,
	output logic carry_out,
	output logic skip_next,
	output logic irq_gate_flag,
	output logic wdog_halt_arm,
	output logic sleep_enter,
	output logic deep_sleep_enter,
	output logic instr_done
);

	// the port read paths are written for a four-bit accumulator;
	// other widths would leave bits undefined, so elaboration stops on them
	if (ACC_WIDTH != ACC_W) begin : g_acc_width_check
		$error("cpio_decoder: ACC_WIDTH must be 4");
	end

	////////////////////////////////////////////////////////////////////////
	// opcode decode
	function automatic logic is_op(input logic [OPCODE_W-1:0] code, input logic [OPCODE_W-1:0] ref_code);
		is_op = (code == ref_code);
	endfunction

	logic dec_mask;
	logic dec_unmask;
	logic dec_wdog;
	logic dec_sleep_arm;
	logic dec_sleep;
	logic dec_deep;
	logic dec_rd_bit;
	logic dec_rd_p0;

	// decode is qualified by instr_valid so idle cycles decode no opcode and change no flag
	always_comb begin
		dec_mask = instr_valid && is_op(instr_opcode, OP_IRQ_MASK);
		dec_unmask = instr_valid && is_op(instr_opcode, OP_IRQ_UNMASK);
		dec_wdog = instr_valid && is_op(instr_opcode, OP_WDOG_HALT_ARM);
		dec_sleep_arm = instr_valid && is_op(instr_opcode, OP_SLEEP_ARM);
		dec_sleep = instr_valid && is_op(instr_opcode, OP_SLEEP);
		dec_deep = instr_valid && is_op(instr_opcode, OP_DEEP_SLEEP);
		dec_rd_bit = instr_valid && is_op(instr_opcode, OP_READ_SINGLE_BIT_PORT);
		dec_rd_p0 = instr_valid && is_op(instr_opcode, OP_READ_PORT_ZERO);
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt gate
	logic gate_reg;
	logic gate_next;

	// mask and unmask are distinct opcodes, so one cycle never asks for both;
	// unknown opcodes fall through and leave the gate as it was
	always_comb begin
		gate_next = gate_reg;
		if (dec_mask) begin
			gate_next = 1'h0;
		end else if (dec_unmask) begin
			gate_next = 1'h1;
		end
	end

	// gate comes out of reset closed, so no request slips in before the program opens it
	always_ff @(posedge clk) begin
		if (rst) begin
			gate_reg <= IRQ_GATE_RESET;
		end else begin
			gate_reg <= gate_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog halt arming
	logic wdog_reg;
	logic wdog_next;

	// sticky until reset: the halt it enables is one-way, so there is no disarm path
	always_comb begin
		wdog_next = wdog_reg;
		if (dec_wdog) begin
			wdog_next = 1'h1;
		end
	end

	// only the watchdog unit acts on this level; this slice never clears it outside reset
	always_ff @(posedge clk) begin
		if (rst) begin
			wdog_reg <= WDOG_ARM_RESET;
		end else begin
			wdog_reg <= wdog_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power-down arming and entry
	logic arm_reg;
	logic arm_next;
	logic sleep_reg;
	logic sleep_next;
	logic deep_reg;
	logic deep_next;

	// any valid instruction replaces the arm, so it covers only the very next one;
	// idle cycles keep it, since no instruction stands between the pair
	always_comb begin
		arm_next = arm_reg;
		sleep_next = 1'h0;
		deep_next = 1'h0;
		if (instr_valid) begin
			arm_next = dec_sleep_arm;
			sleep_next = dec_sleep && arm_reg;
			deep_next = dec_deep && arm_reg;
		end
	end

	// entry strobes last one cycle; an unarmed power-down just retires as a no-op
	always_ff @(posedge clk) begin
		if (rst) begin
			arm_reg <= SLEEP_ARM_RESET;
			sleep_reg <= PULSE_RESET;
			deep_reg <= PULSE_RESET;
		end else begin
			arm_reg <= arm_next;
			sleep_reg <= sleep_next;
			deep_reg <= deep_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// accumulator write-back
	logic [ACC_WIDTH-1:0] acc_reg;
	logic [ACC_WIDTH-1:0] acc_next;
	logic acc_we_reg;
	logic acc_we_next;

	// non-read cycles pass the accumulator through with the write strobe low;
	// the strobe, not acc_out, decides whether the accumulator changes
	always_comb begin
		acc_next = acc_in;
		acc_we_next = 1'h0;
		if (dec_rd_bit) begin
			acc_next = {{(ACC_WIDTH-1){1'h0}}, single_bit_port};
			acc_we_next = 1'h1;
		end else if (dec_rd_p0) begin
			acc_next = quad_io_port_zero;
			acc_we_next = 1'h1;
		end
	end

	// pins are taken as already synchronous; a raw pin here would need a synchroniser first
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_reg <= ACC_RESET;
			acc_we_reg <= PULSE_RESET;
		end else begin
			acc_reg <= acc_next;
			acc_we_reg <= acc_we_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// completion, carry and skip
	logic carry_reg;
	logic carry_next;
	logic done_reg;
	logic done_next;
	logic skip_flag_reg;
	logic skip_flag_next;

	// every instruction here retires in one cycle and never asks for a skip;
	// carry is only passed along so the core can write back uniformly
	always_comb begin
		carry_next = carry_in;
		done_next = instr_valid;
		skip_flag_next = 1'h0;
	end

	// skip is registered too, so every output leaves from a flip-flop
	always_ff @(posedge clk) begin
		if (rst) begin
			carry_reg <= CARRY_RESET;
			done_reg <= PULSE_RESET;
			skip_flag_reg <= PULSE_RESET;
		end else begin
			carry_reg <= carry_next;
			done_reg <= done_next;
			skip_flag_reg <= skip_flag_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	assign acc_out = acc_reg;
	assign acc_we = acc_we_reg;
	assign carry_out = carry_reg;
	assign skip_next = skip_flag_reg;
	assign irq_gate_flag = gate_reg;
	assign wdog_halt_arm = wdog_reg;
	assign sleep_enter = sleep_reg;
	assign deep_sleep_enter = deep_reg;
	assign instr_done = done_reg;

endmodule

// ===== verif/cpio_chk.sv
// assertions for the cpio decoder
`timescale 1ns/10ps
module cpio_chk import cpio_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [9:0] instr_opcode,
	input wire logic carry_in,
	input wire logic single_bit_port,
	input wire logic [3:0] quad_io_port_zero,
	input wire logic [3:0] acc_out,
	input wire logic acc_we,
	input wire logic carry_out,
	input wire logic skip_next,
	input wire logic irq_gate_flag,
	input wire logic wdog_halt_arm,
	input wire logic sleep_enter,
	input wire logic deep_sleep_enter,
	input wire logic instr_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// idle cycles map to 3FF, which no instruction uses
	wire logic [9:0] op = instr_valid ? instr_opcode : 10'h3FF;
	sequence s_arm; op == OP_SLEEP_ARM ##1 op == OP_SLEEP; endsequence
	property p_mask; op == OP_IRQ_MASK |=> !irq_gate_flag; endproperty
	a_mask: assert property (p_mask) else $error("gate set");
	property p_unmask; op == OP_IRQ_UNMASK |=> irq_gate_flag; endproperty
	a_unmask: assert property (p_unmask) else $error("gate clear");
	property p_wdog; op == OP_WDOG_HALT_ARM |=> wdog_halt_arm; endproperty
	a_wdog: assert property (p_wdog) else $error("no arm");
	property p_sleep; s_arm |=> sleep_enter; endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep");
	property p_bit; op == OP_READ_SINGLE_BIT_PORT |=> acc_out[0] == $past(single_bit_port); endproperty
	a_bit: assert property (p_bit) else $error("bit0");
	property p_hi; op == OP_READ_SINGLE_BIT_PORT |=> acc_we && acc_out[3:1] == 3'h0; endproperty
	a_hi: assert property (p_hi) else $error("bits3_1");
	property p_p0; op == OP_READ_PORT_ZERO |=> acc_we && acc_out == $past(quad_io_port_zero); endproperty
	a_p0: assert property (p_p0) else $error("port0");
	property p_one; instr_valid |=> instr_done && !skip_next && carry_out == $past(carry_in); endproperty
	a_one: assert property (p_one) else $error("cycle");
	sequence s_deep_arm; op == OP_SLEEP_ARM ##1 op == OP_DEEP_SLEEP; endsequence
	property p_deep; s_deep_arm |=> deep_sleep_enter; endproperty
	a_deep: assert property (p_deep) else $error("no deep sleep");
	property p_no_pulse; op != OP_SLEEP && op != OP_DEEP_SLEEP |=> !sleep_enter && !deep_sleep_enter; endproperty
	a_no_pulse: assert property (p_no_pulse) else $error("stray sleep");
	property p_gate_hold; op != OP_IRQ_MASK && op != OP_IRQ_UNMASK |=> $stable(irq_gate_flag); endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("gate moved");
	property p_wdog_hold; wdog_halt_arm |=> wdog_halt_arm; endproperty
	a_wdog_hold: assert property (p_wdog_hold) else $error("arm lost");
endmodule
bind cpio_decoder cpio_chk u_chk (
	.clk(clk),
	.rst(rst),
	.instr_valid(instr_valid),
	.instr_opcode(instr_opcode),
	.carry_in(carry_in),
	.single_bit_port(single_bit_port),
	.quad_io_port_zero(quad_io_port_zero),
	.acc_out(acc_out),
	.acc_we(acc_we),
	.carry_out(carry_out),
	.skip_next(skip_next),
	.irq_gate_flag(irq_gate_flag),
	.wdog_halt_arm(wdog_halt_arm),
	.sleep_enter(sleep_enter),
	.deep_sleep_enter(deep_sleep_enter),
	.instr_done(instr_done)
);

// ===== verif/control_and_port_input_ops_test.sv
// bench for the cpio decoder
`timescale 1ns/10ps
module control_and_port_input_ops_test import cpio_pkg::*;;
	logic clk = 1'h0, rst = 1'h1, instr_valid = 1'h0, carry_in = 1'h1, single_bit_port = 1'h1;
	logic [9:0] instr_opcode = 10'h000;
	logic [3:0] acc_in = 4'hF, quad_io_port_zero = 4'hA, acc_out;
	logic acc_we, carry_out, skip_next, irq_gate_flag, wdog_halt_arm, sleep_enter, deep_sleep_enter, instr_done;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	cpio_decoder DUT (
		.clk(clk),
		.rst(rst),
		.instr_valid(instr_valid),
		.instr_opcode(instr_opcode),
		.acc_in(acc_in),
		.carry_in(carry_in),
		.single_bit_port(single_bit_port),
		.quad_io_port_zero(quad_io_port_zero),
		.acc_out(acc_out),
		.acc_we(acc_we),
		.carry_out(carry_out),
		.skip_next(skip_next),
		.irq_gate_flag(irq_gate_flag),
		.wdog_halt_arm(wdog_halt_arm),
		.sleep_enter(sleep_enter),
		.deep_sleep_enter(deep_sleep_enter),
		.instr_done(instr_done)
	);
	always #2 clk = ~clk;
	// run needs under 80 cycles
	always @(posedge clk) if (++cyc > 300) begin
		n_mismatch++;
		summarize();
	end
	task ck(logic [3:0] g, e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %0t %h %h", $time, g, e);
		end
	endtask
	// two opcodes back to back, then idle so results settle
	task go(logic [9:0] a, b);
		@(posedge clk) instr_valid <= 1'h1;
		instr_opcode <= a;
		@(posedge clk) instr_opcode <= b;
		@(posedge clk) instr_valid <= 1'h0;
		#1;
	endtask
	// one opcode after an idle edge, which keeps any arming
	task one(logic [9:0] a);
		@(posedge clk) instr_valid <= 1'h1;
		instr_opcode <= a;
		@(posedge clk) instr_valid <= 1'h0;
		#1;
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task t_ctl;
		go(OP_IRQ_UNMASK, OP_WDOG_HALT_ARM);
		ck({2'h0, irq_gate_flag, wdog_halt_arm}, 4'h3);
		go(OP_IRQ_MASK, OP_SLEEP);
		ck({2'h0, irq_gate_flag, sleep_enter}, 4'h0);
		go(OP_SLEEP_ARM, OP_DEEP_SLEEP);
		ck({3'h0, deep_sleep_enter}, 4'h1);
		go(OP_SLEEP_ARM, OP_SLEEP);
		ck({3'h0, sleep_enter}, 4'h1);
		$display("t_ctl done");
	endtask
	task t_read;
		go(OP_READ_PORT_ZERO, OP_READ_SINGLE_BIT_PORT);
		ck(acc_out, 4'h1);
		ck({acc_we, carry_out, skip_next, instr_done}, 4'hD);
		go(OP_READ_SINGLE_BIT_PORT, OP_READ_PORT_ZERO);
		ck(acc_out, 4'hA);
		$display("t_read done");
	endtask
	// arm lost to another instruction, arm kept across an idle cycle
	task t_arm;
		go(OP_SLEEP_ARM, OP_IRQ_UNMASK);
		one(OP_SLEEP);
		ck({3'h0, sleep_enter}, 4'h0);
		go(OP_IRQ_UNMASK, OP_SLEEP_ARM);
		one(OP_SLEEP);
		ck({3'h0, sleep_enter}, 4'h1);
		ck({3'h0, wdog_halt_arm}, 4'h1);
		$display("t_arm done");
	endtask
	// other pin levels and carry, then an opcode this slice does not know
	task t_port;
		@(posedge clk) single_bit_port <= 1'h0;
		quad_io_port_zero <= 4'h5;
		carry_in <= 1'h0;
		go(OP_READ_PORT_ZERO, OP_READ_SINGLE_BIT_PORT);
		ck(acc_out, 4'h0);
		ck({acc_we, carry_out, skip_next, instr_done}, 4'h9);
		one(OP_READ_PORT_ZERO);
		ck(acc_out, 4'h5);
		go(OP_IRQ_MASK, 10'h1C7);
		ck({2'h0, acc_we, instr_done}, 4'h1);
		ck({3'h0, irq_gate_flag}, 4'h0);
		$display("t_port done");
	endtask
	// reset in mid-run clears the sticky arm; first instruction right at release
	task t_reset;
		@(posedge clk) rst <= 1'h1;
		repeat (2) @(posedge clk);
		#1 ck({irq_gate_flag, wdog_halt_arm, acc_we, instr_done}, 4'h0);
		@(posedge clk) rst <= 1'h0;
		instr_valid <= 1'h1;
		instr_opcode <= OP_IRQ_UNMASK;
		@(posedge clk) instr_valid <= 1'h0;
		#1 ck({3'h0, irq_gate_flag}, 4'h1);
		$display("t_reset done");
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		t_ctl;
		t_read;
		t_arm;
		t_port;
		t_reset;
		summarize();
	end
endmodule
